// File: rtl/alert_pkg.sv
// Shared constants, states and carrier types of the monitor alert logic
package alert_pkg;

    // Register pointers as seen on the two-wire bus
    localparam logic [7:0]  ADDR_CONFIG      = 8'h00;
    localparam logic [7:0]  ADDR_MASK_ENABLE = 8'h06;
    localparam logic [7:0]  ADDR_ALERT_LIMIT = 8'h07;
    localparam logic [7:0]  ADDR_MAKER_ID    = 8'hFE;

    // Field positions in alert_mask_enable
    localparam int          BIT_SHUNT_OVER   = 15;
    localparam int          BIT_FUNC_LOW     = 11;
    localparam int          BIT_CONV_ALERT   = 10;
    localparam int          BIT_AFF          = 4;
    localparam int          BIT_CONV_READY_FLAG         = 3;
    localparam int          BIT_OVF          = 2;
    localparam int          BIT_ALERT_POLARITY         = 1;
    localparam int          BIT_LEN          = 0;

    // Reset values
    localparam logic [15:0] MASK_RESET       = 16'h0000;
    localparam logic [15:0] LIMIT_RESET      = 16'h0000;

    // Operating-mode field of the configuration register
    localparam int          MODE_LSB         = 0;
    localparam logic [2:0]  MODE_OFF_A       = 3'h0;
    localparam logic [2:0]  MODE_OFF_B       = 3'h4;

    // Seven-bit bus address of this device
    localparam logic [6:0]  SLAVE_ADDR       = 7'h40;

    // Bits in one bus byte, counted from zero
    localparam logic [2:0]  LAST_BIT         = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK  = 3'b010,
        ST_RX   = 3'b011,
        ST_TX   = 3'b100,
        ST_MACK = 3'b101
    } link_state_type;

    // Results and events from the measurement datapath
    typedef struct packed {
        logic [15:0] shunt;
        logic [15:0] bus;
        logic [15:0] power;
        logic        shunt_done;
        logic        bus_done;
        logic        power_done;
        logic        cycle_done;
        logic        overflow;
    } meas_type;

    // Register write passed on to the registers outside this block
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_access_type;

endpackage

// File: rtl/pin_sync.sv
// Three-stage synchroniser for pins, output moves when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
    parameter int               WIDTH     = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input  wire logic             mclk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] level_q;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge mclk_i) begin
                if (srst_i) begin
                    stage1_q[g] <= RESET_VAL[g];
                    stage2_q[g] <= RESET_VAL[g];
                    stage3_q[g] <= RESET_VAL[g];
                    level_q[g]  <= RESET_VAL[g];
                end else begin
                    stage1_q[g] <= pin_i[g];
                    stage2_q[g] <= stage1_q[g];
                    stage3_q[g] <= stage2_q[g];
                    // A one-sample glitch never reaches the level
                    if (stage2_q[g] == stage3_q[g]) begin
                        level_q[g] <= stage3_q[g];
                    end
                end
            end
        end
    endgenerate

    assign level_o = level_q;
endmodule

// File: rtl/alert_compare.sv
// Priority selection of one limit function and its comparison against the limit
`timescale 1ns/1ps
module alert_compare (
    input  wire logic              [4:0]  func_en_i,
    input  wire logic              [15:0] limit_i,
    input  wire alert_pkg::meas_type      meas_i,
    output logic                          check_o,
    output logic                          cond_o
);
    logic sel_shunt_over;
    logic sel_shunt_under;
    logic sel_bus_over;
    logic sel_bus_under;
    logic sel_power_over;
    logic shunt_gt;
    logic shunt_lt;
    logic bus_gt;
    logic bus_lt;
    logic power_gt;

    // Highest enabled bit wins, the rest are ignored
    assign sel_shunt_over  = func_en_i[4];
    assign sel_shunt_under = func_en_i[3] & ~func_en_i[4];
    assign sel_bus_over    = func_en_i[2] & ~|func_en_i[4:3];
    assign sel_bus_under   = func_en_i[1] & ~|func_en_i[4:2];
    assign sel_power_over  = func_en_i[0] & ~|func_en_i[4:1];

    // Shunt voltage is two's complement, bus and power are unsigned
    assign shunt_gt = $signed(meas_i.shunt) > $signed(limit_i);
    assign shunt_lt = $signed(meas_i.shunt) < $signed(limit_i);
    assign bus_gt   = meas_i.bus > limit_i;
    assign bus_lt   = meas_i.bus < limit_i;
    assign power_gt = meas_i.power > limit_i;

    // Compare only after the conversion that feeds the selected function
    assign check_o = ((sel_shunt_over | sel_shunt_under) & meas_i.shunt_done)
                   | ((sel_bus_over | sel_bus_under) & meas_i.bus_done)
                   | (sel_power_over & meas_i.power_done);

    assign cond_o = (sel_shunt_over & shunt_gt) | (sel_shunt_under & shunt_lt)
                  | (sel_bus_over & bus_gt) | (sel_bus_under & bus_lt)
                  | (sel_power_over & power_gt);
endmodule

// File: rtl/monitor_alert_logic.sv
// Alert and status logic of a current and power monitor with its two-wire register port
`timescale 1ns/1ps
module monitor_alert_logic #(
    // Arbitrary neutral value
    parameter logic [15:0] MAKER_CODE = 16'h1357
) (
    input  wire logic                      mclk_i,
    input  wire logic                      srst_i,
    input  wire logic                      scl_i,
    input  wire logic                      sda_i,
    output logic                           sda_o,
    output logic                           sda_oe_o,
    output logic                           alert_o,
    output logic                           alert_oe_o,
    input  wire alert_pkg::meas_type       meas_i,
    output alert_pkg::reg_access_type      reg_access_o,
    input  wire logic               [15:0] ext_rdata_i
);
    // Bus pins and edge detection
    logic [1:0]                scl_sda_s;
    logic                      scl_s;
    logic                      sda_s;
    logic                      scl_p_q;
    logic                      sda_p_q;
    logic                      scl_rise;
    logic                      scl_fall;
    logic                      bus_start;
    logic                      bus_stop;

    // Bus slave state
    alert_pkg::link_state_type state_q;
    logic [2:0]                bit_cnt_q;
    logic [7:0]                rx_sr_q;
    logic                      byte_done_q;
    logic [1:0]                byte_idx_q;
    logic                      rw_q;
    logic                      mack_nack_q;
    logic [7:0]                ptr_q;
    logic [7:0]                msb_q;
    logic [15:0]               tx_q;
    logic                      sda_oe_q;
    logic                      addr_done;
    logic                      addr_match;
    logic                      rd_load;
    logic                      wr_now;
    logic [15:0]               wr_word;
    logic [15:0]               rd_word;
    alert_pkg::reg_access_type access_q;

    // Register contents and flags
    logic [5:0]                en_q;
    logic                      alert_polarity_q;
    logic                      alert_latch_enable_q;
    logic                      alert_function_flag_q;
    logic                      conv_ready_flag_q;
    logic                      math_overflow_flag_q;
    logic [15:0]               alert_threshold_bits_q;
    logic [15:0]               mask_word;
    logic                      mask_rd;
    logic                      cfg_clr;
    logic                      check;
    logic                      cond;
    logic                      alert_active;
    logic                      alert_oe_q;

    function automatic logic is_power_down(input logic [2:0] mode);
        return (mode == alert_pkg::MODE_OFF_A) || (mode == alert_pkg::MODE_OFF_B);
    endfunction

    pin_sync #(
        .WIDTH     (2),
        .RESET_VAL (2'h3)
    ) u_pin_sync (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .pin_i   ({scl_i, sda_i}),
        .level_o (scl_sda_s)
    );

    assign scl_s     = scl_sda_s[1];
    assign sda_s     = scl_sda_s[0];
    assign scl_rise  = scl_s & ~scl_p_q;
    assign scl_fall  = ~scl_s & scl_p_q;
    assign bus_start = scl_s & scl_p_q & ~sda_s & sda_p_q;
    assign bus_stop  = scl_s & scl_p_q & sda_s & ~sda_p_q;

    // Byte boundaries are acted on at the falling clock edge after the eighth bit
    assign addr_done  = (state_q == alert_pkg::ST_ADDR) & scl_fall & byte_done_q;
    assign addr_match = rx_sr_q[7:1] == alert_pkg::SLAVE_ADDR;
    assign rd_load    = addr_done & addr_match & rx_sr_q[0];
    assign wr_now     = (state_q == alert_pkg::ST_RX) & scl_fall & byte_done_q
                      & (byte_idx_q == 2'h2);
    assign wr_word    = {msb_q, rx_sr_q};

    assign mask_word = {en_q, 5'h00, alert_function_flag_q, conv_ready_flag_q,
                        math_overflow_flag_q, alert_polarity_q, alert_latch_enable_q};

    // Other pointers go to the result and configuration registers outside
    assign rd_word = (ptr_q == alert_pkg::ADDR_MASK_ENABLE) ? mask_word :
                     (ptr_q == alert_pkg::ADDR_ALERT_LIMIT) ? alert_threshold_bits_q :
                     (ptr_q == alert_pkg::ADDR_MAKER_ID)    ? MAKER_CODE :
                     ext_rdata_i;

    // The snapshot is taken on the same edge as the clear, so nothing is lost
    assign mask_rd = rd_load & (ptr_q == alert_pkg::ADDR_MASK_ENABLE);
    assign cfg_clr = wr_now & (ptr_q == alert_pkg::ADDR_CONFIG)
                   & ~is_power_down(wr_word[alert_pkg::MODE_LSB +: 3]);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_q     <= alert_pkg::ST_IDLE;
            bit_cnt_q   <= 3'h0;
            rx_sr_q     <= 8'h00;
            byte_done_q <= 1'b0;
            byte_idx_q  <= 2'h0;
            rw_q        <= 1'b0;
            mack_nack_q <= 1'b0;
            ptr_q       <= 8'h00;
            msb_q       <= 8'h00;
            tx_q        <= 16'h0000;
            sda_oe_q    <= 1'b0;
        end else if (bus_start) begin
            // A repeated start keeps the pointer for the following read
            state_q     <= alert_pkg::ST_ADDR;
            bit_cnt_q   <= 3'h0;
            byte_done_q <= 1'b0;
            byte_idx_q  <= 2'h0;
            sda_oe_q    <= 1'b0;
        end else if (bus_stop) begin
            state_q  <= alert_pkg::ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                alert_pkg::ST_ADDR, alert_pkg::ST_RX: begin
                    if (scl_rise) begin
                        rx_sr_q     <= {rx_sr_q[6:0], sda_s};
                        bit_cnt_q   <= bit_cnt_q + 3'h1;
                        byte_done_q <= bit_cnt_q == alert_pkg::LAST_BIT;
                    end else if (scl_fall && byte_done_q) begin
                        byte_done_q <= 1'b0;
                        if (state_q == alert_pkg::ST_ADDR) begin
                            if (addr_match) begin
                                rw_q     <= rx_sr_q[0];
                                tx_q     <= rd_word;
                                sda_oe_q <= 1'b1;
                                state_q  <= alert_pkg::ST_ACK;
                            end else begin
                                state_q <= alert_pkg::ST_IDLE;
                            end
                        end else begin
                            case (byte_idx_q)
                                2'h0:    ptr_q <= rx_sr_q;
                                2'h1:    msb_q <= rx_sr_q;
                                default: ptr_q <= ptr_q;
                            endcase
                            byte_idx_q <= (byte_idx_q == 2'h2) ? 2'h1 : byte_idx_q + 2'h1;
                            sda_oe_q   <= 1'b1;
                            state_q    <= alert_pkg::ST_ACK;
                        end
                    end
                end
                alert_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 3'h0;
                        if (rw_q) begin
                            sda_oe_q <= ~tx_q[15];
                            state_q  <= alert_pkg::ST_TX;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q  <= alert_pkg::ST_RX;
                        end
                    end
                end
                alert_pkg::ST_TX: begin
                    if (scl_fall) begin
                        // Rotating lets a long read repeat the same word
                        tx_q      <= {tx_q[14:0], tx_q[15]};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == alert_pkg::LAST_BIT) begin
                            sda_oe_q <= 1'b0;
                            state_q  <= alert_pkg::ST_MACK;
                        end else begin
                            sda_oe_q <= ~tx_q[14];
                        end
                    end
                end
                alert_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        mack_nack_q <= sda_s;
                    end else if (scl_fall) begin
                        bit_cnt_q <= 3'h0;
                        if (mack_nack_q) begin
                            state_q <= alert_pkg::ST_IDLE;
                        end else begin
                            sda_oe_q <= ~tx_q[15];
                            state_q  <= alert_pkg::ST_TX;
                        end
                    end
                end
                default: begin
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            access_q <= '0;
        end else begin
            access_q.wr <= wr_now;
            if (wr_now) begin
                access_q.addr  <= ptr_q;
                access_q.wdata <= wr_word;
            end
        end
    end

    localparam logic [5:0] MASK_RESET_EN =
        alert_pkg::MASK_RESET[alert_pkg::BIT_SHUNT_OVER:alert_pkg::BIT_CONV_ALERT];

    // Only the enable and pin-control bits are writable; flags are status
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            en_q                   <= MASK_RESET_EN;
            alert_polarity_q       <= alert_pkg::MASK_RESET[alert_pkg::BIT_ALERT_POLARITY];
            alert_latch_enable_q   <= alert_pkg::MASK_RESET[alert_pkg::BIT_LEN];
            alert_threshold_bits_q <= alert_pkg::LIMIT_RESET;
        end else if (wr_now) begin
            if (ptr_q == alert_pkg::ADDR_MASK_ENABLE) begin
                en_q                 <= wr_word[alert_pkg::BIT_SHUNT_OVER:alert_pkg::BIT_CONV_ALERT];
                alert_polarity_q     <= wr_word[alert_pkg::BIT_ALERT_POLARITY];
                alert_latch_enable_q <= wr_word[alert_pkg::BIT_LEN];
            end
            if (ptr_q == alert_pkg::ADDR_ALERT_LIMIT) begin
                alert_threshold_bits_q <= wr_word;
            end
        end
    end

    alert_compare u_alert_compare (
        .func_en_i (en_q[5:1]),
        .limit_i   (alert_threshold_bits_q),
        .meas_i    (meas_i),
        .check_o   (check),
        .cond_o    (cond)
    );

    // Flags: a setting event always wins over a clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            alert_function_flag_q <= 1'b0;
            conv_ready_flag_q     <= 1'b0;
            math_overflow_flag_q  <= 1'b0;
        end else begin
            if (check && cond) begin
                alert_function_flag_q <= 1'b1;
            end else if (alert_latch_enable_q ? mask_rd : check) begin
                alert_function_flag_q <= 1'b0;
            end
            if (meas_i.cycle_done) begin
                conv_ready_flag_q <= 1'b1;
            end else if (mask_rd || cfg_clr) begin
                conv_ready_flag_q <= 1'b0;
            end
            if (meas_i.overflow) begin
                math_overflow_flag_q <= 1'b1;
            end else if (mask_rd) begin
                math_overflow_flag_q <= 1'b0;
            end
        end
    end

    // The limit alert shares the latched or transparent state of its flag
    assign alert_active = alert_function_flag_q
                        | (en_q[0] & conv_ready_flag_q);

    // Open collector: pull low when active-low asserted or active-high idle
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            alert_oe_q <= 1'b0;
        end else begin
            alert_oe_q <= alert_active ^ alert_polarity_q;
        end
    end

    assign sda_o        = 1'b0;
    assign sda_oe_o     = sda_oe_q;
    assign alert_o      = 1'b0;
    assign alert_oe_o   = alert_oe_q;
    assign reg_access_o = access_q;
endmodule

// File: verification/bus_host_model.sv
// Two-wire bus host that drives clock and data toward the alert logic
`timescale 1ns/1ps
module bus_host_model (
    input  wire logic mclk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // Data moves mid low phase, four cycles clear of either clock edge
    task automatic bit_io(input logic b, output logic r);
        tick(4);
        sda_low_o <= ~b;
        tick(4);
        scl_o <= 1'b1;
        tick(4);
        r = sda_i;
        tick(4);
        scl_o <= 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                           output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(last, nak);
    endtask
    task automatic start();
        sda_low_o <= 1'b1;
        tick(8);
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        tick(4);
        sda_low_o <= 1'b1;
        tick(4);
        scl_o <= 1'b1;
        tick(8);
        sda_low_o <= 1'b0;
        tick(8);
    endtask
    // Pointer only when full is low; nak collects every missed acknowledge
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] p, input logic [15:0] v,
                             input logic full, output logic nak);
        logic [7:0] q;
        logic       a;
        start();
        byte_io({dev, 1'b0}, 1'b1, q, nak);
        byte_io(p, 1'b1, q, a);
        nak = nak | a;
        if (full) begin
            byte_io(v[15:8], 1'b1, q, a);
            nak = nak | a;
            byte_io(v[7:0], 1'b1, q, a);
            nak = nak | a;
        end
        stop();
    endtask
    task automatic read_reg(input logic [7:0] p, output logic [15:0] v);
        logic n;
        write_reg(alert_pkg::SLAVE_ADDR, p, 16'h0000, 1'b0, n);
        start();
        byte_io({alert_pkg::SLAVE_ADDR, 1'b1}, 1'b1, v[15:8], n);
        byte_io(8'hFF, 1'b0, v[15:8], n);
        byte_io(8'hFF, 1'b1, v[7:0], n);
        stop();
    endtask
endmodule

// File: verification/monitor_alert_logic_asserts.sv
// Checks on the alert pin, data pin and register write port
`timescale 1ns/1ps
module alert_checker (
    input wire logic                      mclk_i,
    input wire logic                      srst_i,
    input wire logic                      scl_i,
    input wire logic                      sda_o,
    input wire logic                      sda_oe_o,
    input wire logic                      alert_o,
    input wire logic                      alert_oe_o,
    input wire alert_pkg::meas_type       meas_i,
    input wire alert_pkg::reg_access_type reg_access_o
);
    // Shadows lag the real registers a cycle; no events come near writes
    logic [15:0] mask_q;
    logic [15:0] limit_q;
    wire logic       wr_mask = reg_access_o.wr && reg_access_o.addr == alert_pkg::ADDR_MASK_ENABLE;
    wire logic       wr_lim  = reg_access_o.wr && reg_access_o.addr == alert_pkg::ADDR_ALERT_LIMIT;
    wire logic [4:0] en      = mask_q[15:11];
    wire logic       check   = (en[4] | en[3]) ? meas_i.shunt_done :
                               (en[2] | en[1]) ? meas_i.bus_done : en[0] & meas_i.power_done;
    wire logic       cond    = en[4] ? $signed(meas_i.shunt) > $signed(limit_q) :
                               en[3] ? $signed(meas_i.shunt) < $signed(limit_q) :
                               en[2] ? meas_i.bus > limit_q :
                               en[1] ? meas_i.bus < limit_q : meas_i.power > limit_q;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mask_q <= alert_pkg::MASK_RESET;
            limit_q <= alert_pkg::LIMIT_RESET;
        end else if (wr_mask) begin
            mask_q <= reg_access_o.wdata;
        end else if (wr_lim) begin
            limit_q <= reg_access_o.wdata;
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);
    a_alert_pin_open: assert property (alert_o == 1'b0)
        else $error("alert pin driven high");
    a_sda_pin_open: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    a_limit_hit_sets: assert property (check && cond |-> ##2 alert_oe_o != mask_q[1])
        else $error("limit hit gave no alert");
    a_quiet_clears: assert property (check && !cond && !mask_q[0] && !mask_q[10]
        |-> ##2 alert_oe_o == mask_q[1])
        else $error("transparent alert did not clear");
    a_ready_alert: assert property (mask_q[10] && meas_i.cycle_done
        |-> ##2 alert_oe_o != mask_q[1])
        else $error("ready gave no alert");
    a_polarity_flip: assert property (wr_mask && reg_access_o.wdata[1] != mask_q[1]
        && reg_access_o.wdata[10] == mask_q[10] |=> alert_oe_o != $past(alert_oe_o))
        else $error("polarity change not seen on pin");
    a_write_one_pulse: assert property (reg_access_o.wr |=> !reg_access_o.wr)
        else $error("write strobe longer than one cycle");
    a_sda_in_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data pin moved while clock high");
    cover property (check && cond);
    cover property (wr_mask && reg_access_o.wdata[0]);
    cover property (mask_q[10] && meas_i.cycle_done);
endmodule
bind monitor_alert_logic alert_checker u_alert_checker (
    .mclk_i(mclk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .alert_o(alert_o), .alert_oe_o(alert_oe_o), .meas_i(meas_i),
    .reg_access_o(reg_access_o));

// File: verification/monitor_alert_logic_test.sv
// Self-checking bench for the monitor alert logic
`timescale 1ns/1ps
module monitor_alert_logic_test;
    localparam logic [15:0] MAKER = 16'h2B6D; // Arbitrary code
    localparam logic [15:0] EXT   = 16'hA5C3;
    localparam logic [7:0]  MSK   = alert_pkg::ADDR_MASK_ENABLE;
    localparam logic [7:0]  LIM   = alert_pkg::ADDR_ALERT_LIMIT;
    localparam logic [7:0]  MID   = alert_pkg::ADDR_MAKER_ID;
    localparam logic [7:0]  CFG   = alert_pkg::ADDR_CONFIG;
    logic                mclk;
    logic                srst;
    logic                scl;
    logic                host_low;
    logic                sda_oe;
    logic                alert_oe;
    alert_pkg::meas_type meas;
    int                  bad_count;
    int                  total_checks;
    wire logic           sda = ~(host_low | sda_oe);
    monitor_alert_logic #(.MAKER_CODE(MAKER)) DUT (
        .mclk_i(mclk), .srst_i(srst), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(sda_oe), .alert_o(), .alert_oe_o(alert_oe), .meas_i(meas),
        .reg_access_o(), .ext_rdata_i(EXT));
    bus_host_model host (.mclk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    always #50 mclk = ~mclk;
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] v);
        logic n;
        host.write_reg(alert_pkg::SLAVE_ADDR, p, v, 1'b1, n);
        chk1(n, 1'b0);
    endtask
    task automatic rd_chk(input logic [7:0] p, input logic [15:0] exp);
        logic [15:0] v;
        host.read_reg(p, v);
        chk16(v, exp);
    endtask
    // Results are levels and stay put; only the done and overflow flags pulse
    task automatic ev(input logic [4:0] f, input logic [15:0] v);
        @(posedge mclk);
        meas <= {v, v, v, f};
        @(posedge mclk);
        meas <= {v, v, v, 5'h00};
        repeat (4) @(posedge mclk);
    endtask
    task automatic t_regs();
        logic n;
        rd_chk(MSK, alert_pkg::MASK_RESET);
        rd_chk(LIM, alert_pkg::LIMIT_RESET);
        wr(MID, 16'h0000);
        rd_chk(MID, MAKER);
        rd_chk(8'h01, EXT);
        wr(LIM, 16'h8001);
        rd_chk(LIM, 16'h8001);
        wr(MSK, 16'hFFFF);
        rd_chk(MSK, 16'hFC03);
        host.write_reg(7'h22, LIM, 16'h1234, 1'b1, n);
        chk1(n, 1'b1);
        rd_chk(LIM, 16'h8001);
        $display("test regs done");
    endtask
    task automatic t_funcs();
        logic [4:0] f;
        logic       under;
        wr(LIM, 16'h0100);
        for (int i = 0; i < 5; i++) begin
            f = (i < 2) ? 5'h10 : (i < 4) ? 5'h08 : 5'h04;
            under = (i == 1) || (i == 3);
            wr(MSK, 16'h8000 >> i);
            ev(f, under ? 16'h00FF : 16'h0101);
            chk1(alert_oe, 1'b1);
            ev(f, 16'h0100);
            chk1(alert_oe, 1'b0);
        end
        wr(MSK, 16'hC000);
        ev(5'h10, 16'h0050);
        chk1(alert_oe, 1'b0);
        ev(5'h10, 16'hFF00);
        chk1(alert_oe, 1'b0);
        ev(5'h10, 16'h0101);
        rd_chk(MSK, 16'hC010);
        ev(5'h10, 16'h0100);
        chk1(alert_oe, 1'b0);
        $display("test funcs done");
    endtask
    task automatic t_latch();
        wr(MSK, 16'h2001);
        ev(5'h10, 16'h9000);
        chk1(alert_oe, 1'b0);
        ev(5'h08, 16'h9000);
        chk1(alert_oe, 1'b1);
        ev(5'h08, 16'h0000);
        chk1(alert_oe, 1'b1);
        rd_chk(MSK, 16'h2011);
        chk1(alert_oe, 1'b0);
        $display("test latch done");
    endtask
    task automatic t_ready();
        wr(MSK, 16'h0402);
        chk1(alert_oe, 1'b1);
        ev(5'h03, 16'h0000);
        chk1(alert_oe, 1'b0);
        wr(MSK, 16'h0400);
        wr(CFG, 16'h4000);
        chk1(alert_oe, 1'b1);
        wr(CFG, 16'h0004);
        chk1(alert_oe, 1'b1);
        wr(CFG, 16'h0007);
        chk1(alert_oe, 1'b0);
        ev(5'h02, 16'h0000);
        rd_chk(MSK, 16'h040C);
        chk1(alert_oe, 1'b0);
        rd_chk(MSK, 16'h0400);
        $display("test ready done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        srst = 1'b1;
        meas = '0;
        bad_count = 0;
        total_checks = 0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        repeat (8) @(posedge mclk);
        t_regs();
        t_funcs();
        t_latch();
        t_ready();
        end_sim();
    end
    // A hang anywhere counts as a mismatch
    initial begin
        repeat (90000) @(posedge mclk);
        bad_count++;
        end_sim();
    end
endmodule
